// *** rtl/ulpfc_pkg.sv ***
// Constants for the low-power and flow-control block of the UART.
// Assumes a 32-bit AXI4-Lite register bus and a UART core that reports its own status.
package ulpfc_pkg;

    // Register bus.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int LANE_LO = 0;
    localparam int LANE_HI = 1;

    // Mode register fields.
    localparam int MODE_WAKE_BIT = 7;
    localparam int MODE_PIN_LO = 8;
    localparam int MODE_PIN_HI = 9;
    localparam int MODE_RTS_MODE_SELECT_BIT = 11;
    localparam int MODE_STOP_IN_IDLE_BIT = 13;
    localparam logic [1:0] PIN_USE_RTS = 2'h1;
    localparam logic [1:0] PIN_USE_RTS_CTS = 2'h2;
    localparam logic [1:0] PIN_USE_RST = 2'h0;

    // Control and status fields.
    localparam int CTRL_RXIE_BIT = 0;
    localparam int STAT_RXIF_BIT = 0;
    localparam int STAT_CTS_BIT = 1;
    localparam int STAT_RTS_BIT = 2;
    localparam int STAT_STOP_BIT = 3;
    localparam int STAT_WOKE_BIT = 4;

    // Pin default levels.
    localparam logic TX_IDLE = 1'h1;
    localparam logic BCLK_IDLE = 1'h0;
    localparam logic RTS_DEASSERT = 1'h1;
    localparam logic PIN_IDLE = 1'h1;

    // Received word handed to DMA.
    localparam int RXW_W = 16;
    localparam int RXW_PERR_BIT = 11;
    localparam int RXW_FERR_BIT = 10;
    localparam logic [7:0] DUMMY_BYTE = 8'h00;

endpackage : ulpfc_pkg

// *** rtl/ulpfc_sync.sv ***
// Three-stage synchroniser with agreement filter for an asynchronous pin.
// Assumes the pin is a plain level from outside the clk_sys domain.
`timescale 1ns/1ns
module ulpfc_sync #(
    parameter logic RST_VAL = 1'h1
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Pin and filtered level.
    input wire logic pin_in,
    output logic level_out
);
    import ulpfc_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } ulpfc_sync_t;

    localparam ulpfc_sync_t SYNC_RST = '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, lvl: RST_VAL};

    ulpfc_sync_t s_q;
    ulpfc_sync_t s_d;

    // The first stage feeds only the second; the filter compares stages two and three.
    always_comb begin
        s_d = s_q;
        s_d.s1 = pin_in;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        if (s_q.s2 == s_q.s3) begin
            s_d.lvl = s_q.s3;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= SYNC_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign level_out = s_q.lvl;

endmodule : ulpfc_sync

// *** rtl/ulpfc_rxword.sv ***
// Builds the 16-bit received word for DMA and handles the character lost on wake.
// Assumes char_valid is a one-cycle pulse from the receiver core.
`timescale 1ns/1ns
module ulpfc_rxword (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Wake event and received character.
    input wire logic wake_evt,
    input wire logic char_valid,
    input wire logic [7:0] char_data,
    input wire logic char_perr,
    input wire logic char_ferr,
    // Word towards DMA.
    output logic word_valid,
    output logic [ulpfc_pkg::RXW_W-1:0] word_data
);
    import ulpfc_pkg::*;

    typedef struct packed {
        logic drop;
        logic vld;
        logic [RXW_W-1:0] data;
    } ulpfc_rxw_t;

    ulpfc_rxw_t s_q;
    ulpfc_rxw_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.vld = 1'h0;
        if (wake_evt) begin
            // The wake edge itself is the first receive event; it yields no real data.
            s_d.vld = 1'h1;
            s_d.data = {{(RXW_W-8){1'h0}}, DUMMY_BYTE};
            s_d.drop = 1'h1;
        end else if (char_valid) begin
            if (s_q.drop) begin
                // Clocks were still settling while this character arrived, so it is discarded.
                s_d.drop = 1'h0;
            end else begin
                s_d.vld = 1'h1;
                s_d.data = {{(RXW_W-8){1'h0}}, char_data};
                s_d.data[RXW_PERR_BIT] = char_perr;
                s_d.data[RXW_FERR_BIT] = char_ferr;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign word_valid = s_q.vld;
    assign word_data = s_q.data;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_wake_dummy_word: assert property (wake_evt |=> word_valid && word_data[7:0] == DUMMY_BYTE)
        else $error("wake did not yield a dummy word");
    chk_first_char_lost: assert property ((char_valid && s_q.drop && !wake_evt) |=> !word_valid)
        else $error("first character after wake was not dropped");
    chk_status_flags: assert property ((char_valid && !s_q.drop && !wake_evt) |=>
        word_valid && word_data[RXW_PERR_BIT] == $past(char_perr) && word_data[RXW_FERR_BIT] == $past(char_ferr)
        && word_data[7:0] == $past(char_data))
        else $error("received word status or data wrong");
    cov_char_dropped: cover property (wake_evt ##[1:50] (char_valid && s_q.drop));

endmodule : ulpfc_rxword

// *** rtl/ulpfc_top.sv ***
// Low-power handling and hardware flow control of the UART, with an AXI4-Lite register slave.
// Assumes sleep_req, idle_req and the core status inputs come from logic on clk_sys,
// and that this block stays clocked while it gates the UART core clock off.
`timescale 1ns/1ns
module ulpfc_top (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // AXI4-Lite write address and data.
    input wire logic [ulpfc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ulpfc_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [ulpfc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [ulpfc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Power mode requests and effects.
    input wire logic sleep_req,
    input wire logic idle_req,
    output logic uart_clk_en,
    output logic xfer_abort,
    output logic wake_req,
    output logic rx_int_flag,
    // Status from the UART core, and the transmit permission back to it.
    input wire logic rx_buf_full,
    input wire logic rx_shifting,
    input wire logic rx_overrun_error,
    input wire logic tx_shift_empty,
    input wire logic tx_bit_start,
    input wire logic tx_serial,
    input wire logic baud16_in,
    output logic tx_start_ok,
    // Received characters from the core and words towards DMA.
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char_data,
    input wire logic rx_char_perr,
    input wire logic rx_char_ferr,
    output logic rx_word_valid,
    output logic [ulpfc_pkg::RXW_W-1:0] rx_word_data,
    // Pins.
    input wire logic rx_pin,
    input wire logic cts_n,
    output logic tx_pin,
    output logic baud_clock_output,
    output logic rts_n_o,
    output logic rts_n_oe_n
);
    import ulpfc_pkg::*;

    typedef struct packed {
        logic awrdy;
        logic awv;
        logic [ADDR_W-1:0] awa;
        logic wrdy;
        logic wv;
        logic [DATA_W-1:0] wd;
        logic [3:0] ws;
        logic bv;
        logic [1:0] br;
        logic arrdy;
        logic rv;
        logic [DATA_W-1:0] rd;
        logic [1:0] rr;
        logic wake_en;
        logic [1:0] pin_use;
        logic rts_md;
        logic stop_in_idle;
        logic rxie;
        logic rxif;
        logic stopped;
        logic woke;
        logic abort;
        logic wake;
        logic clk_en;
        logic cts_ok;
        logic tx_ok;
        logic tx_pin;
        logic bclk;
        logic rts_n;
        logic rts_oe_n;
        logic rx_prev;
    } ulpfc_state_t;

    localparam ulpfc_state_t ST_RST = '{awrdy: 1'h1, wrdy: 1'h1, arrdy: 1'h1, pin_use: PIN_USE_RST,
        clk_en: 1'h1, cts_ok: 1'h1, tx_ok: 1'h1, tx_pin: TX_IDLE, bclk: BCLK_IDLE,
        rts_n: RTS_DEASSERT, rts_oe_n: 1'h1, rx_prev: PIN_IDLE, default: '0};

    ulpfc_state_t s_q;
    ulpfc_state_t s_d;

    logic rx_lvl;
    logic cts_lvl;
    logic rx_fall;
    logic rx_rise;
    logic stop_now;
    logic wr_go;
    logic rts_drive;
    logic cts_used;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        addr_hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction : addr_hit

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = addr_hit(a, ADDR_MODE) || addr_hit(a, ADDR_CTRL) || addr_hit(a, ADDR_STAT);
    endfunction : addr_mapped

    // Both pins idle high, so the filters start at the idle level and see no edge at reset.
    ulpfc_sync #(
        .RST_VAL(PIN_IDLE)
    ) u_rx_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_in(rx_pin),
        .level_out(rx_lvl)
    );

    // One filtered sample per clock; a cts_n pulse caught on fewer than two clocks in a row is missed.
    ulpfc_sync #(
        .RST_VAL(PIN_IDLE)
    ) u_cts_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_in(cts_n),
        .level_out(cts_lvl)
    );

    ulpfc_rxword u_rxword (
        .clk_sys(clk_sys),
        .rst(rst),
        .wake_evt(s_q.wake),
        .char_valid(rx_char_valid),
        .char_data(rx_char_data),
        .char_perr(rx_char_perr),
        .char_ferr(rx_char_ferr),
        .word_valid(rx_word_valid),
        .word_data(rx_word_data)
    );

    assign rx_fall = s_q.rx_prev && !rx_lvl;
    assign rx_rise = !s_q.rx_prev && rx_lvl;
    assign stop_now = sleep_req || (idle_req && s_q.stop_in_idle);
    assign wr_go = s_q.awv && s_q.wv && !s_q.bv;
    assign rts_drive = (s_q.pin_use == PIN_USE_RTS) || (s_q.pin_use == PIN_USE_RTS_CTS);
    assign cts_used = (s_q.pin_use == PIN_USE_RTS_CTS);

    always_comb begin
        s_d = s_q;
        s_d.rx_prev = rx_lvl;
        s_d.stopped = stop_now;
        s_d.abort = stop_now && !s_q.stopped;
        s_d.clk_en = !stop_now;
        s_d.wake = 1'h0;

        // Pins fall back to their idle levels whenever the UART is stopped.
        s_d.tx_pin = stop_now ? TX_IDLE : tx_serial;
        s_d.bclk = stop_now ? BCLK_IDLE : baud16_in;

        // Wake on a start bit; the clear of wake_enable waits for the line to return high.
        if (s_q.stopped && s_q.wake_en && rx_fall) begin
            s_d.wake = 1'h1;
            s_d.woke = 1'h1;
        end else if (s_q.woke && rx_rise) begin
            s_d.woke = 1'h0;
            s_d.wake_en = 1'h0;
        end

        // Clear-to-send is taken only at the start of a bit period.
        if (cts_used) begin
            if (tx_bit_start) begin
                s_d.cts_ok = !cts_lvl;
            end
        end else begin
            s_d.cts_ok = 1'h1;
        end
        s_d.tx_ok = s_d.cts_ok && !stop_now;

        // Request-to-send in flow-control or simplex mode.
        s_d.rts_oe_n = !rts_drive;
        if (stop_now) begin
            s_d.rts_n = RTS_DEASSERT;
        end else if (s_q.rts_md) begin
            s_d.rts_n = tx_shift_empty;
        end else begin
            s_d.rts_n = rx_buf_full || rx_shifting || rx_overrun_error;
        end

        // Write channel: address and data are held until both are present.
        if (s_axi_awvalid && s_q.awrdy) begin
            s_d.awv = 1'h1;
            s_d.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wrdy) begin
            s_d.wv = 1'h1;
            s_d.wd = s_axi_wdata;
            s_d.ws = s_axi_wstrb;
        end
        if (s_q.bv && s_axi_bready) begin
            s_d.bv = 1'h0;
        end
        if (wr_go) begin
            s_d.awv = 1'h0;
            s_d.wv = 1'h0;
            s_d.bv = 1'h1;
            s_d.br = addr_mapped(s_q.awa) ? RESP_OKAY : RESP_SLVERR;
            if (addr_hit(s_q.awa, ADDR_MODE)) begin
                // A software write of wake_enable lands after the hardware clear, so software wins.
                if (s_q.ws[LANE_LO]) begin
                    s_d.wake_en = s_q.wd[MODE_WAKE_BIT];
                end
                if (s_q.ws[LANE_HI]) begin
                    s_d.pin_use = s_q.wd[MODE_PIN_HI:MODE_PIN_LO];
                    s_d.rts_md = s_q.wd[MODE_RTS_MODE_SELECT_BIT];
                    s_d.stop_in_idle = s_q.wd[MODE_STOP_IN_IDLE_BIT];
                end
            end
            if (addr_hit(s_q.awa, ADDR_CTRL) && s_q.ws[LANE_LO]) begin
                s_d.rxie = s_q.wd[CTRL_RXIE_BIT];
            end
            if (addr_hit(s_q.awa, ADDR_STAT) && s_q.ws[LANE_LO] && s_q.wd[STAT_RXIF_BIT]) begin
                s_d.rxif = 1'h0;
            end
        end
        // The flag set is applied after the software clear so a wake in that cycle is kept.
        if (s_d.wake && s_q.rxie) begin
            s_d.rxif = 1'h1;
        end
        s_d.awrdy = !s_d.awv;
        s_d.wrdy = !s_d.wv;

        // Read channel: one read at a time, data captured when the address is taken.
        if (s_q.rv && s_axi_rready) begin
            s_d.rv = 1'h0;
        end
        if (s_axi_arvalid && s_q.arrdy) begin
            s_d.rv = 1'h1;
            s_d.rd = '0;
            s_d.rr = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            if (addr_hit(s_axi_araddr, ADDR_MODE)) begin
                s_d.rd[MODE_WAKE_BIT] = s_q.wake_en;
                s_d.rd[MODE_PIN_HI:MODE_PIN_LO] = s_q.pin_use;
                s_d.rd[MODE_RTS_MODE_SELECT_BIT] = s_q.rts_md;
                s_d.rd[MODE_STOP_IN_IDLE_BIT] = s_q.stop_in_idle;
            end else if (addr_hit(s_axi_araddr, ADDR_CTRL)) begin
                s_d.rd[CTRL_RXIE_BIT] = s_q.rxie;
            end else if (addr_hit(s_axi_araddr, ADDR_STAT)) begin
                s_d.rd[STAT_RXIF_BIT] = s_q.rxif;
                s_d.rd[STAT_CTS_BIT] = cts_lvl;
                s_d.rd[STAT_RTS_BIT] = s_q.rts_n;
                s_d.rd[STAT_STOP_BIT] = s_q.stopped;
                s_d.rd[STAT_WOKE_BIT] = s_q.woke;
            end
        end
        s_d.arrdy = !s_d.rv;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = s_q.awrdy;
    assign s_axi_wready = s_q.wrdy;
    assign s_axi_bresp = s_q.br;
    assign s_axi_bvalid = s_q.bv;
    assign s_axi_arready = s_q.arrdy;
    assign s_axi_rdata = s_q.rd;
    assign s_axi_rresp = s_q.rr;
    assign s_axi_rvalid = s_q.rv;
    assign uart_clk_en = s_q.clk_en;
    assign xfer_abort = s_q.abort;
    assign wake_req = s_q.wake;
    assign rx_int_flag = s_q.rxif;
    assign tx_start_ok = s_q.tx_ok;
    assign tx_pin = s_q.tx_pin;
    assign baud_clock_output = s_q.bclk;
    assign rts_n_o = s_q.rts_n;
    assign rts_n_oe_n = s_q.rts_oe_n;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_clock_held_low: assert property (stop_now |=> !uart_clk_en && !baud_clock_output)
        else $error("clock not held low while stopped");
    chk_abort_on_entry: assert property ((stop_now && !s_q.stopped) |=>
        xfer_abort && tx_pin == TX_IDLE && rts_n_o == RTS_DEASSERT)
        else $error("sleep entry did not abort and idle the pins");
    chk_wake_sets_flag: assert property ((s_q.stopped && s_q.wake_en && s_q.rxie && rx_fall) |=>
        wake_req && rx_int_flag)
        else $error("wake edge did not raise the receive flag");
    chk_wake_self_clear: assert property ((s_q.woke && rx_rise
        && !(wr_go && addr_hit(s_q.awa, ADDR_MODE))) |=> !s_q.wake_en && !s_q.woke)
        else $error("wake enable not cleared on rising edge");
    chk_idle_keeps_run: assert property ((idle_req && !sleep_req && !s_q.stop_in_idle) |=> uart_clk_en && !s_q.stopped)
        else $error("idle stopped the uart with stop_in_idle clear");
    chk_cts_blocks_start: assert property ((cts_used && tx_bit_start && cts_lvl) |=> !tx_start_ok)
        else $error("transmit allowed while cts_n high");
    chk_cts_sample_low: assert property ((cts_used && tx_bit_start && !cts_lvl && !stop_now) |=> tx_start_ok)
        else $error("transmit not allowed after cts_n sampled low");
    chk_cts_held_between: assert property ((cts_used && !tx_bit_start && !stop_now
        && !$past(stop_now)) |=> tx_start_ok == $past(tx_start_ok))
        else $error("cts sample changed outside a bit start");
    chk_rts_enable: assert property (rts_drive |=> !rts_n_oe_n)
        else $error("rts_n not driven in rts modes");
    chk_rts_ignored: assert property (!rts_drive |=> rts_n_oe_n && tx_start_ok == !$past(stop_now))
        else $error("rts_n driven or cts_n used outside rts modes");
    // Reset is sampled here as well: at the release edge the registers still hold their reset levels.
    chk_rts_ready: assert property ((!rst && !stop_now && !s_q.rts_md && !rx_buf_full && !rx_shifting
        && !rx_overrun_error) |=> !rts_n_o)
        else $error("rts_n high while receiver can accept");
    chk_rts_busy: assert property ((!stop_now && !s_q.rts_md && (rx_buf_full || rx_shifting)) |=> rts_n_o)
        else $error("rts_n low while receiver busy");
    chk_rts_simplex: assert property ((!stop_now && s_q.rts_md) |=> rts_n_o == $past(tx_shift_empty))
        else $error("simplex rts_n does not follow transmit pending");

    cov_wake_event: cover property (s_q.stopped ##1 wake_req ##[1:200] !s_q.woke);
    cov_simplex_send: cover property (s_q.rts_md && !rts_n_o ##[1:100] rts_n_o);
    cov_cts_hold: cover property (cts_used && !tx_start_ok ##[1:100] tx_start_ok);

endmodule : ulpfc_top

// *** testbench/ulpfc_far.sv ***
// Far-end terminal model: drives rx_pin and cts_n and watches the request-to-send line.
// Assumes the bench resolves rts_n with its pull-up and hands the level in as rts_line.
`timescale 1ns/1ns
module ulpfc_far (
    // Clock and line.
    input wire logic clk_sys,
    input wire logic rts_line,
    input wire logic follow,
    // Pins towards the device.
    output logic rx_pin,
    output logic cts_n
);
    // In simplex the far end answers request-to-send with clear-to-send.
    // The answer follows a registered line, so each level lasts at least a cycle.
    assign cts_n = follow ? rts_line : 1'h1;
    initial rx_pin = 1'h1;
    task automatic set_rx(input logic v);
        @(posedge clk_sys);
        rx_pin <= v;
        repeat (2) @(posedge clk_sys);
    endtask : set_rx
endmodule : ulpfc_far

// *** testbench/ulpfc_top_tb.sv ***
// Self-checking bench for the low-power and flow-control block.
// Assumes the far end is the ulpfc_far model and rts_n has a pull-up on the board.
`timescale 1ns/1ns
module ulpfc_top_tb;
    import ulpfc_pkg::*;
    logic clk_sys = 0, rst = 1, follow = 0;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, wq = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic sleep_req = 0, idle_req = 0, rx_buf_full = 0, rx_shifting = 0, rx_overrun_error = 0;
    logic tx_shift_empty = 1, tx_bit_start = 0, tx_serial = 0, baud16_in = 0;
    logic rx_char_valid = 0, rx_char_perr = 0, rx_char_ferr = 0;
    logic [7:0] rx_char_data = 8'h3C;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] rx_word_data;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic uart_clk_en, xfer_abort, wake_req, rx_int_flag, tx_start_ok, rx_word_valid;
    logic tx_pin, baud_clock_output, rts_n_o, rts_n_oe_n, rx_pin, cts_n, rts_line;
    int failures = 0, cmp_count = 0, cyc = 0, wcnt = 0, acnt = 0, kcnt = 0, i, n;
    // Released line floats high through the pull-up.
    assign rts_line = rts_n_oe_n ? 1'h1 : rts_n_o;
    ulpfc_top DUT (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .sleep_req(sleep_req), .idle_req(idle_req), .uart_clk_en(uart_clk_en), .xfer_abort(xfer_abort),
        .wake_req(wake_req), .rx_int_flag(rx_int_flag), .rx_buf_full(rx_buf_full), .rx_shifting(rx_shifting),
        .rx_overrun_error(rx_overrun_error), .tx_shift_empty(tx_shift_empty), .tx_bit_start(tx_bit_start),
        .tx_serial(tx_serial), .baud16_in(baud16_in), .tx_start_ok(tx_start_ok), .rx_char_valid(rx_char_valid),
        .rx_char_data(rx_char_data), .rx_char_perr(rx_char_perr), .rx_char_ferr(rx_char_ferr),
        .rx_word_valid(rx_word_valid), .rx_word_data(rx_word_data), .rx_pin(rx_pin), .cts_n(cts_n),
        .tx_pin(tx_pin), .baud_clock_output(baud_clock_output), .rts_n_o(rts_n_o), .rts_n_oe_n(rts_n_oe_n));
    ulpfc_far FAR (.clk_sys(clk_sys), .rts_line(rts_line), .follow(follow), .rx_pin(rx_pin), .cts_n(cts_n));
    initial forever #4 clk_sys = ~clk_sys;
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        cmp(s_axi_bresp, er);
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        cmp(s_axi_rdata, ed);
        cmp(s_axi_rresp, er);
    endtask : axi_rd
    task automatic send_char(input logic p, input logic f);
        @(posedge clk_sys);
        rx_char_valid <= 1'h1;
        rx_char_perr <= p;
        rx_char_ferr <= f;
        @(posedge clk_sys);
        rx_char_valid <= 1'h0;
        repeat (2) @(posedge clk_sys);
    endtask : send_char
    always @(posedge clk_sys) begin
        baud16_in <= ~baud16_in;
        if (rx_word_valid === 1'h1) wq <= rx_word_data;
        if (rx_word_valid === 1'h1) wcnt <= wcnt + 1;
        if (xfer_abort === 1'h1) acnt <= acnt + 1;
        if (wake_req === 1'h1) kcnt <= kcnt + 1;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'h0;
        axi_rd(4'hC, 32'h0, RESP_SLVERR);
        for (i = 0; i < 4; i++) begin
            rx_char_data <= rx_char_data + 8'h11;
            send_char(i[1], i[0]);
            cmp(wq, {4'h0, i[1], i[0], 2'h0, rx_char_data});
        end
        for (i = 0; i < 4; i++) begin
            axi_wr(ADDR_MODE, 32'(i << 8), RESP_OKAY);
            repeat (2) @(posedge clk_sys);
            cmp(rts_n_oe_n, !(i == 1 || i == 2));
        end
        axi_wr(ADDR_MODE, 32'h100, RESP_OKAY);
        for (i = 0; i < 4; i++) begin
            rx_buf_full <= i == 1;
            rx_shifting <= i == 2;
            rx_overrun_error <= i == 3;
            repeat (3) @(posedge clk_sys);
            cmp(rts_n_o, i != 0);
        end
        rx_overrun_error <= 1'h0;
        follow <= 1'h1;
        axi_wr(ADDR_MODE, 32'hA00, RESP_OKAY);
        for (i = 0; i < 3; i++) begin
            tx_shift_empty <= i != 1;
            repeat (8) @(posedge clk_sys);
            cmp(rts_n_o, i != 1);
            if (i < 2) tx_bit_start <= 1'h1;
            @(posedge clk_sys);
            tx_bit_start <= 1'h0;
            repeat (2) @(posedge clk_sys);
            // Without a new bit start the last sample must stand.
            cmp(tx_start_ok, i != 0);
        end
        follow <= 1'h0;
        axi_wr(ADDR_MODE, 32'h100, RESP_OKAY);
        idle_req <= 1'h1;
        repeat (3) @(posedge clk_sys);
        cmp(uart_clk_en, 1'h1);
        cmp(tx_pin, 1'h0);
        // The baud clock output lags the toggling core clock by one cycle while running.
        cmp(baud_clock_output, !baud16_in);
        axi_wr(ADDR_MODE, 32'h2100, RESP_OKAY);
        repeat (3) @(posedge clk_sys);
        cmp(uart_clk_en, 1'h0);
        cmp({tx_pin, rts_n_o, baud_clock_output}, 3'b110);
        cmp(acnt, 1);
        idle_req <= 1'h0;
        axi_wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        axi_wr(ADDR_MODE, 32'h80, RESP_OKAY);
        sleep_req <= 1'h1;
        n = wcnt;
        FAR.set_rx(1'h0);
        repeat (8) @(posedge clk_sys);
        cmp(kcnt, 1);
        cmp(rx_int_flag, 1'h1);
        cmp(wcnt, n + 1);
        cmp(wq, 32'h0);
        send_char(1'h0, 1'h0);
        cmp(wcnt, n + 1);
        FAR.set_rx(1'h1);
        repeat (6) @(posedge clk_sys);
        axi_rd(ADDR_MODE, 32'h0, RESP_OKAY);
        sleep_req <= 1'h0;
        axi_wr(ADDR_STAT, 32'h1, RESP_OKAY);
        cmp(rx_int_flag, 1'h0);
        give_verdict();
    end
endmodule : ulpfc_top_tb
